// [hw/acpi_pme_power_ok_control.sv]
// power-management event, power-good sequencing and reset-output control
// assumes an APB master on sys_clk, event sources on sys_clk and three
// asynchronous pins (power-good low stage, LPC reset, ring indicate B)
//
// What this block does
// - intrusion clear bit held, not self-clearing
// - keep last-state flag, one means off
// - first power-good stage 300 or 200 ms
// - second stage none, 32, 96, 250 ms
// - retrigger bit reruns power-good, self-clears
// - third key set matched when enabled
// - second key set matched when enabled
// - os wake key pulses power switch
// - half-second low pulse on-recovery power switch
// - watchdog reset from LPC or power-good
// - monitor reset from power-good or LPC
// - five reset-output enables, reset value 7c
// - master enable gates the event output
// - low status flags latch, write-one clears
// - high status flags latch, write-one clears
// - low enable bits gate matching sources
// - high enable bits gate matching sources
// - mouse wake selector high bit kept
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module acpi_pme_power_ok_control #(
    parameter int unsigned PG1_SLOW_CYC = pme_pkg::PG1_SLOW_CYC,
    parameter int unsigned PG1_FAST_CYC = pme_pkg::PG1_FAST_CYC,
    parameter int unsigned PG2_SHORT_CYC = pme_pkg::PG2_SHORT_CYC,
    parameter int unsigned PG2_MID_CYC = pme_pkg::PG2_MID_CYC,
    parameter int unsigned PG2_LONG_CYC = pme_pkg::PG2_LONG_CYC,
    parameter int unsigned ON_PULSE_CYC = pme_pkg::ON_PULSE_CYC,
    parameter int unsigned OS_PULSE_CYC = pme_pkg::OS_PULSE_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pme_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event sources on sys_clk
    input wire pme_pkg::low_events_t lowEvents,
    input wire logic hardwareMonitorIrq,
    input wire logic watchdogTimeoutN,
    // keyboard wake inputs on sys_clk
    input wire logic keyboardWakeEnable,
    input wire logic [2:0] keySetMatch,
    input wire logic osWakeKey,
    input wire logic powerLossOnRecover,
    // asynchronous pins
    input wire logic powerGoodLowStagePin,
    input wire logic lpcResetPinN,
    input wire logic ringIndicateBPinN,
    // outputs
    output logic pmeN,
    output logic powerGoodMidStage,
    output logic powerGoodOut,
    output logic powerSwitchOutN,
    output logic keyboardWakeEvent,
    output logic [4:0] resetOutputN,
    output logic watchdogResetN,
    output logic hardwareMonitorResetN,
    output logic chassisIntrusionClear,
    output logic lastStateOff,
    output logic mouseWakeSelectHi
);

    function automatic logic [pme_pkg::ADDR_W-1:0] regAddr(
        input logic [9:0] idx);
        regAddr = {idx, 2'b00};
    endfunction

    function automatic pme_pkg::count_t toCount(input int unsigned cyc);
        toCount = pme_pkg::CNT_W'(cyc);
    endfunction

    logic [7:0] pgMiscReg, wakeOptReg, rstOutReg;
    logic [7:0] statLoReg, statHiReg, enLoReg, enHiReg;
    logic retrigReg;
    logic [31:0] prdataReg;
    logic preadyReg, pslverrReg;
    logic [2:0] pinS1, pinS2, pinS3, pinFilt;
    pme_pkg::pg_state_t pgState, pgNext;
    pme_pkg::count_t pgCnt, pgCntNext, psCnt, psCntNext;
    logic pmeNReg, midReg, pgOutReg, psOutNReg, kbWakeReg;
    logic [4:0] rstOutNReg;
    logic wdtRstNReg, hmRstNReg;

    // address decode and strobes
    wire setupPhase = psel & ~penable;
    wire accessDone = psel & penable & pready;
    wire wrStrobe = accessDone & pwrite;
    wire [7:0] wrByte = pwdata[7:0];
    wire hitPg = paddr == regAddr(pme_pkg::IDX_PG_MISC);
    wire hitWake = paddr == regAddr(pme_pkg::IDX_WAKE_OPT);
    wire hitRstOut = paddr == regAddr(pme_pkg::IDX_RST_OUT);
    wire hitStLo = paddr == regAddr(pme_pkg::IDX_STAT_LO);
    wire hitStHi = paddr == regAddr(pme_pkg::IDX_STAT_HI);
    wire hitEnLo = paddr == regAddr(pme_pkg::IDX_EN_LO);
    wire hitEnHi = paddr == regAddr(pme_pkg::IDX_EN_HI);
    wire wrPg = wrStrobe & hitPg;
    wire retrigWrite = wrPg & wrByte[pme_pkg::RETRIG_BIT];

    // filtered pin levels
    wire lowStage = pinFilt[0];
    wire lpcResetN = pinFilt[1];
    wire ringN = pinFilt[2];

    // read mux; reserved words read zero without error
    logic [7:0] readByte;
    logic hitAny;
    always_comb begin
        readByte = pme_pkg::BYTE_ZERO;
        hitAny = 1'b1;
        if (hitPg) begin
            readByte = {pgMiscReg[7:1], retrigReg};
        end else if (hitWake) begin
            readByte = wakeOptReg;
        end else if (hitRstOut) begin
            readByte = rstOutReg;
        end else if (hitStLo) begin
            readByte = statLoReg;
        end else if (hitStHi) begin
            readByte = statHiReg;
        end else if (hitEnLo) begin
            readByte = enLoReg;
        end else if (hitEnHi) begin
            readByte = enHiReg;
        end else if (paddr == regAddr(pme_pkg::IDX_RSVD_E8)) begin
            readByte = pme_pkg::BYTE_ZERO;
        end else if (paddr == regAddr(pme_pkg::IDX_RSVD_E9)) begin
            readByte = pme_pkg::BYTE_ZERO;
        end else begin
            hitAny = 1'b0;
        end
    end

    // apb answer: one wait-free access cycle after every setup cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdataReg <= 32'h00000000;
            preadyReg <= 1'b0;
            pslverrReg <= 1'b0;
        end else begin
            preadyReg <= setupPhase;
            pslverrReg <= setupPhase & ~hitAny;
            if (setupPhase) begin
                prdataReg <= {24'h000000, readByte};
            end
        end
    end

    // pin synchronisers; a change counts once stages two and three agree
    // stages reset to the idle pin levels so no false edge follows reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinS1 <= 3'h6;
            pinS2 <= 3'h6;
            pinS3 <= 3'h6;
            pinFilt <= 3'h6;
        end else begin
            pinS1 <= {ringIndicateBPinN, lpcResetPinN, powerGoodLowStagePin};
            pinS2 <= pinS1;
            pinS3 <= pinS2;
            pinFilt <= (pinS2 & pinS3) | (pinFilt & (pinS2 | pinS3));
        end
    end

    // event sources; ring indicate and watchdog timeout are active low
    wire [7:0] setLo = {2'b00, lowEvents} & pme_pkg::STAT_LO_MASK;
    wire [7:0] setHi = {4'h0, hardwareMonitorIrq, ~watchdogTimeoutN,
                        1'b0, ~ringN};
    // a set in the clear cycle wins so no event is lost
    wire [7:0] clrLo = (wrStrobe & hitStLo) ? wrByte : pme_pkg::BYTE_ZERO;
    wire [7:0] clrHi = (wrStrobe & hitStHi) ? wrByte : pme_pkg::BYTE_ZERO;
    wire [7:0] statLoNext = (statLoReg & ~clrLo) | setLo;
    wire [7:0] statHiNext = (statHiReg & ~clrHi) | setHi;
    wire [7:0] pendLo = statLoReg & enLoReg;
    wire [7:0] pendHi = statHiReg & enHiReg;
    wire masterEn = rstOutReg[pme_pkg::MASTER_EN_BIT];
    wire pmeNext = masterEn & (|{pendLo, pendHi});

    // configuration registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pgMiscReg <= pme_pkg::PG_MISC_RST;
            wakeOptReg <= pme_pkg::WAKE_OPT_RST;
            rstOutReg <= pme_pkg::RST_OUT_RST;
            enLoReg <= pme_pkg::BYTE_ZERO;
            enHiReg <= pme_pkg::BYTE_ZERO;
            retrigReg <= 1'b0;
        end else begin
            // intrusion clear stays as written; software re-arms it
            if (wrPg) begin
                pgMiscReg <= wrByte & pme_pkg::PG_MISC_MASK;
            end
            if (wrStrobe & hitWake) begin
                wakeOptReg <= wrByte & pme_pkg::WAKE_OPT_MASK;
            end
            if (wrStrobe & hitRstOut) begin
                rstOutReg <= wrByte & pme_pkg::RST_OUT_MASK;
            end
            if (wrStrobe & hitEnLo) begin
                enLoReg <= wrByte & pme_pkg::STAT_LO_MASK;
            end
            if (wrStrobe & hitEnHi) begin
                enHiReg <= wrByte & pme_pkg::STAT_HI_MASK;
            end
            retrigReg <= retrigWrite;
        end
    end

    // sticky status
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            statLoReg <= pme_pkg::BYTE_ZERO;
            statHiReg <= pme_pkg::BYTE_ZERO;
        end else begin
            statLoReg <= statLoNext;
            statHiReg <= statHiNext;
        end
    end

    // power-good sequencer; counts use the lower bound of each range
    wire [1:0] pg2Sel = pgMiscReg[pme_pkg::PG2_SEL_LSB +: 2];
    wire pg1Fast = pgMiscReg[pme_pkg::PG1_FAST_BIT];
    wire pme_pkg::count_t pg1Load = pg1Fast ? toCount(PG1_FAST_CYC)
                                            : toCount(PG1_SLOW_CYC);
    wire pme_pkg::count_t pg2Load =
        (pg2Sel == pme_pkg::PG2_SHORT) ? toCount(PG2_SHORT_CYC) :
        (pg2Sel == pme_pkg::PG2_MID) ? toCount(PG2_MID_CYC) :
        toCount(PG2_LONG_CYC);
    always_comb begin
        pgNext = pgState;
        pgCntNext = pgCnt;
        case (pgState)
            pme_pkg::PG_OFF: begin
                if (lowStage) begin
                    pgNext = pme_pkg::PG_STAGE1;
                    pgCntNext = pg1Load - pme_pkg::CNT_ONE;
                end
            end
            pme_pkg::PG_STAGE1: begin
                if (pgCnt != pme_pkg::CNT_ZERO) begin
                    pgCntNext = pgCnt - pme_pkg::CNT_ONE;
                end else if (pg2Sel == pme_pkg::PG2_NONE) begin
                    pgNext = pme_pkg::PG_ON;
                end else begin
                    pgNext = pme_pkg::PG_STAGE2;
                    pgCntNext = pg2Load - pme_pkg::CNT_ONE;
                end
            end
            pme_pkg::PG_STAGE2: begin
                if (pgCnt != pme_pkg::CNT_ZERO) begin
                    pgCntNext = pgCnt - pme_pkg::CNT_ONE;
                end else begin
                    pgNext = pme_pkg::PG_ON;
                end
            end
            default: begin
                pgCntNext = pme_pkg::CNT_ZERO;
            end
        endcase
        // losing the low stage or a retrigger drops the sequence
        if (!lowStage || retrigWrite) begin
            pgNext = pme_pkg::PG_OFF;
            pgCntNext = pme_pkg::CNT_ZERO;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pgState <= pme_pkg::PG_OFF;
            pgCnt <= pme_pkg::CNT_ZERO;
        end else begin
            pgState <= pgNext;
            pgCnt <= pgCntNext;
        end
    end

    // power-switch pulse; a running pulse ignores new triggers
    wire onTrig = powerLossOnRecover & wakeOptReg[pme_pkg::ON_PULSE_BIT];
    wire osTrig = osWakeKey & keyboardWakeEnable
                  & wakeOptReg[pme_pkg::OS_KEY_BIT];
    wire psIdle = psCnt == pme_pkg::CNT_ZERO;
    always_comb begin
        psCntNext = psCnt;
        if (!psIdle) begin
            psCntNext = psCnt - pme_pkg::CNT_ONE;
        end else if (onTrig) begin
            psCntNext = toCount(ON_PULSE_CYC);
        end else if (osTrig) begin
            psCntNext = toCount(OS_PULSE_CYC);
        end
    end

    // key sets two and three count only while enabled
    wire kbWakeNext = keySetMatch[0]
        | (keySetMatch[1] & wakeOptReg[pme_pkg::KEY_SET2_BIT])
        | (keySetMatch[2] & wakeOptReg[pme_pkg::KEY_SET3_BIT]);

    // reset outputs follow the filtered LPC reset when enabled
    wire [4:0] rstEn = rstOutReg[pme_pkg::RST_EN_LSB +: 5];
    wire [4:0] rstOutNext = ~(rstEn & {5{~lpcResetN}});
    wire wdtRstNext = wakeOptReg[pme_pkg::WDT_SRC_BIT] ? pgOutReg
                                                       : lpcResetN;
    wire hmRstNext = wakeOptReg[pme_pkg::HM_SRC_BIT] ? lpcResetN
                                                     : pgOutReg;

    // output flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            psCnt <= pme_pkg::CNT_ZERO;
            psOutNReg <= 1'b1;
            pmeNReg <= 1'b1;
            midReg <= 1'b0;
            pgOutReg <= 1'b0;
            kbWakeReg <= 1'b0;
            rstOutNReg <= 5'h00;
            wdtRstNReg <= 1'b0;
            hmRstNReg <= 1'b0;
        end else begin
            psCnt <= psCntNext;
            psOutNReg <= psCntNext == pme_pkg::CNT_ZERO;
            pmeNReg <= ~pmeNext;
            midReg <= (pgNext == pme_pkg::PG_STAGE2)
                      | (pgNext == pme_pkg::PG_ON);
            pgOutReg <= pgNext == pme_pkg::PG_ON;
            kbWakeReg <= kbWakeNext;
            rstOutNReg <= rstOutNext;
            wdtRstNReg <= wdtRstNext;
            hmRstNReg <= hmRstNext;
        end
    end

    assign prdata = prdataReg;
    assign pready = preadyReg;
    assign pslverr = pslverrReg;
    assign pmeN = pmeNReg;
    assign powerGoodMidStage = midReg;
    assign powerGoodOut = pgOutReg;
    assign powerSwitchOutN = psOutNReg;
    assign keyboardWakeEvent = kbWakeReg;
    assign resetOutputN = rstOutNReg;
    assign watchdogResetN = wdtRstNReg;
    assign hardwareMonitorResetN = hmRstNReg;
    assign chassisIntrusionClear = pgMiscReg[pme_pkg::INTRUSION_CLR_BIT];
    assign lastStateOff = pgMiscReg[pme_pkg::LAST_OFF_BIT];
    assign mouseWakeSelectHi = pgMiscReg[pme_pkg::MOUSE_SEL_BIT];

    // checks
    chk_event_output: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (masterEn && (|pendLo)) |=> !pmeN)
        else $error("event output not asserted for pending source");
    chk_master_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !masterEn [*2] |-> pmeN)
        else $error("event output active with master disabled");
    chk_status_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (statLoReg[5] && !(wrStrobe && hitStLo && wrByte[5]))
        |=> statLoReg[5])
        else $error("low status flag lost without a clear");
    chk_high_set_wins: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        hardwareMonitorIrq |=> statHiReg[pme_pkg::HM_EVT_BIT])
        else $error("monitor event not latched");
    chk_intrusion_hold: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (chassisIntrusionClear && !wrPg) |=> chassisIntrusionClear)
        else $error("intrusion clear bit changed by itself");
    chk_retrig_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        retrigWrite |=> (!powerGoodOut && retrigReg) ##1 !retrigReg)
        else $error("retrigger did not drop power-good or self-clear");
    chk_pg_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(powerGoodOut) |-> powerGoodMidStage && lowStage)
        else $error("power-good rose out of order");
    chk_on_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (psIdle && onTrig) |=> !powerSwitchOutN [*8])
        else $error("recovery pulse on power switch too short");
    chk_rst_disable: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        !rstEn[0] [*2] |-> resetOutputN[0])
        else $error("disabled reset output asserted");
    chk_wdt_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wakeOptReg[pme_pkg::WDT_SRC_BIT] |=>
        watchdogResetN == $past(pgOutReg))
        else $error("watchdog reset not following power-good");
    chk_key_set_gate: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (keySetMatch == 3'b100 && !wakeOptReg[pme_pkg::KEY_SET3_BIT])
        |=> !keyboardWakeEvent)
        else $error("disabled key set produced a wake");
endmodule

// [hw/pme_pkg.sv]
// constants, register map and types of the power-management event block
// assumes a 20 MHz system clock and a 32-bit APB register bus
package pme_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    // power-good first stage, lower bound of each range
    localparam int unsigned PG1_SLOW_MS = 300;
    localparam int unsigned PG1_FAST_MS = 200;
    localparam int unsigned PG1_SLOW_CYC = PG1_SLOW_MS * CYC_PER_MS;
    localparam int unsigned PG1_FAST_CYC = PG1_FAST_MS * CYC_PER_MS;
    // power-good second stage
    localparam int unsigned PG2_SHORT_MS = 32;
    localparam int unsigned PG2_MID_MS = 96;
    localparam int unsigned PG2_LONG_MS = 250;
    localparam int unsigned PG2_SHORT_CYC = PG2_SHORT_MS * CYC_PER_MS;
    localparam int unsigned PG2_MID_CYC = PG2_MID_MS * CYC_PER_MS;
    localparam int unsigned PG2_LONG_CYC = PG2_LONG_MS * CYC_PER_MS;
    // power-switch pulses
    localparam int unsigned ON_PULSE_MS = 500;
    localparam int unsigned ON_PULSE_CYC = ON_PULSE_MS * CYC_PER_MS;
    localparam int unsigned OS_PULSE_US = 100;
    localparam int unsigned OS_PULSE_CYC = OS_PULSE_US * CYC_PER_US;
    localparam int CNT_W = 24;
    typedef logic [CNT_W-1:0] count_t;
    localparam count_t CNT_ZERO = 24'h000000;
    localparam count_t CNT_ONE = 24'h000001;
    // register indexes; byte address is four times the index
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_PG_MISC = 10'h0e6;
    localparam logic [9:0] IDX_WAKE_OPT = 10'h0e7;
    localparam logic [9:0] IDX_RSVD_E8 = 10'h0e8;
    localparam logic [9:0] IDX_RSVD_E9 = 10'h0e9;
    localparam logic [9:0] IDX_RST_OUT = 10'h0f2;
    localparam logic [9:0] IDX_STAT_LO = 10'h0f3;
    localparam logic [9:0] IDX_STAT_HI = 10'h0f4;
    localparam logic [9:0] IDX_EN_LO = 10'h0f6;
    localparam logic [9:0] IDX_EN_HI = 10'h0f7;
    // reset values and writable masks
    localparam logic [7:0] PG_MISC_RST = 8'h1c;
    localparam logic [7:0] PG_MISC_MASK = 8'hbe;
    localparam logic [7:0] WAKE_OPT_RST = 8'h00;
    localparam logic [7:0] WAKE_OPT_MASK = 8'hf9;
    localparam logic [7:0] RST_OUT_RST = 8'h7c;
    localparam logic [7:0] RST_OUT_MASK = 8'h7d;
    localparam logic [7:0] STAT_LO_MASK = 8'h3f;
    localparam logic [7:0] STAT_HI_MASK = 8'h0d;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // field positions
    localparam int MOUSE_SEL_BIT = 7;
    localparam int INTRUSION_CLR_BIT = 5;
    localparam int LAST_OFF_BIT = 4;
    localparam int PG1_FAST_BIT = 3;
    localparam int PG2_SEL_LSB = 1;
    localparam int RETRIG_BIT = 0;
    localparam int KEY_SET3_BIT = 7;
    localparam int KEY_SET2_BIT = 6;
    localparam int OS_KEY_BIT = 5;
    localparam int ON_PULSE_BIT = 4;
    localparam int WDT_SRC_BIT = 3;
    localparam int HM_SRC_BIT = 0;
    localparam int RST_EN_LSB = 2;
    localparam int MASTER_EN_BIT = 0;
    localparam int HM_EVT_BIT = 3;
    localparam int WDT_EVT_BIT = 2;
    localparam int RING_EVT_BIT = 0;
    // second-stage delay codes
    localparam logic [1:0] PG2_NONE = 2'b00;
    localparam logic [1:0] PG2_SHORT = 2'b01;
    localparam logic [1:0] PG2_MID = 2'b10;
    // event sources of the low status register, bit 5 down to 0
    typedef struct packed {
        logic mouse;
        logic keyboardController;
        logic printerPort;
        logic floppyController;
        logic firstUart;
        logic secondUart;
    } low_events_t;
    typedef enum logic [1:0] {
        PG_OFF = 2'b00,
        PG_STAGE1 = 2'b01,
        PG_STAGE2 = 2'b10,
        PG_ON = 2'b11
    } pg_state_t;
endpackage

// [tb/apb_host_model.sv]
// host side model: issues apb transfers on behalf of the chipset
// assumes a slave that answers with pready; the bench timeout ends hangs
`timescale 1ns/1ps
module apb_host_model (
    // clock
    input wire logic sys_clk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // one transfer; an idle edge first so psel is never driven twice at once
    task automatic xfer(input logic w, input logic [9:0] idx,
            input logic [7:0] d, output logic [7:0] q, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // hold everything until pready is seen high at an edge
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// [tb/tb_acpi_pme_power_ok_control.sv]
// self-checking bench for the power-management event block
// assumes shortened delay parameters so the run stays brief
`timescale 1ns/1ps
module tb_acpi_pme_power_ok_control;
    localparam int T1 = 30;
    localparam int T2 = 20;
    localparam int ON = 16;
    logic sysClk = 1'b0;
    logic rstN = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    pme_pkg::low_events_t lowEv = 6'h00;
    logic hmIrq = 1'b0, wdtN = 1'b1, kbEn = 1'b0, osKey = 1'b0;
    logic lossOn = 1'b0, lowStage = 1'b0, lpcN = 1'b1, ringN = 1'b1;
    logic [2:0] keyMatch = 3'h0;
    logic pmeN, pgMid, pgOut, pswN, kbWake, wdtRstN, hmRstN;
    logic intrClr, lastOff, mouseHi;
    logic [4:0] rstOutN;
    logic [7:0] q;
    int errCount = 0, cmpCount = 0, cyc = 0, n;
    always #25 sysClk = ~sysClk;
    apb_host_model host (.sys_clk(sysClk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    acpi_pme_power_ok_control #(.PG1_SLOW_CYC(40), .PG1_FAST_CYC(T1),
        .PG2_SHORT_CYC(10), .PG2_MID_CYC(T2), .PG2_LONG_CYC(25),
        .ON_PULSE_CYC(ON), .OS_PULSE_CYC(9)) DUT (
        .sys_clk(sysClk), .rst_n(rstN), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lowEvents(lowEv),
        .hardwareMonitorIrq(hmIrq), .watchdogTimeoutN(wdtN),
        .keyboardWakeEnable(kbEn), .keySetMatch(keyMatch),
        .osWakeKey(osKey), .powerLossOnRecover(lossOn),
        .powerGoodLowStagePin(lowStage), .lpcResetPinN(lpcN),
        .ringIndicateBPinN(ringN), .pmeN(pmeN), .powerGoodMidStage(pgMid),
        .powerGoodOut(pgOut), .powerSwitchOutN(pswN),
        .keyboardWakeEvent(kbWake), .resetOutputN(rstOutN),
        .watchdogResetN(wdtRstN), .hardwareMonitorResetN(hmRstN),
        .chassisIntrusionClear(intrClr), .lastStateOff(lastOff),
        .mouseWakeSelectHi(mouseHi));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        host.xfer(1'b1, idx, d, q, e);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
        host.xfer(1'b0, idx, 8'h00, q, e);
        chk(q, exp);
    endtask
    task automatic results();
        if (errCount == 0 && cmpCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sysClk) begin
        cyc++;
        if (cyc == 20000) begin
            errCount++;
            results();
        end
    end
    // reset values, reserved and unmapped places
    task automatic reset_map();
        rd(pme_pkg::IDX_PG_MISC, 8'h1c);
        chk(lastOff, 1'b1);
        rd(pme_pkg::IDX_RST_OUT, 8'h7c);
        chk(rstOutN, 5'h1f);
        rd(pme_pkg::IDX_RSVD_E8, 8'h00);
        host.xfer(1'b0, 10'h0ff, 8'h00, q, e);
        chk(e, 1'b1);
    endtask
    // latched events, gating and write-one-to-clear
    task automatic events();
        wr(pme_pkg::IDX_RST_OUT, 8'h7d);
        wr(pme_pkg::IDX_EN_LO, 8'h20);
        @(posedge sysClk);
        lowEv <= 6'h21;
        @(posedge sysClk);
        lowEv <= 6'h00;
        repeat (3) @(posedge sysClk);
        chk(pmeN, 1'b0);
        rd(pme_pkg::IDX_STAT_LO, 8'h21);
        wr(pme_pkg::IDX_STAT_LO, 8'h20);
        repeat (2) @(posedge sysClk);
        chk(pmeN, 1'b1);
        rd(pme_pkg::IDX_STAT_LO, 8'h01);
        // master off: a pending enabled ring event must stay silent
        wr(pme_pkg::IDX_RST_OUT, 8'h7c);
        wr(pme_pkg::IDX_EN_HI, 8'h01);
        ringN <= 1'b0;
        repeat (6) @(posedge sysClk);
        ringN <= 1'b1;
        repeat (6) @(posedge sysClk);
        rd(pme_pkg::IDX_STAT_HI, 8'h01);
        chk(pmeN, 1'b1);
        wr(pme_pkg::IDX_RST_OUT, 8'h7d);
        repeat (2) @(posedge sysClk);
        chk(pmeN, 1'b0);
    endtask
    // intrusion clear level and power-good sequencing
    task automatic power_good();
        wr(pme_pkg::IDX_PG_MISC, 8'h3c);
        @(posedge sysClk);
        chk(intrClr, 1'b1);
        rd(pme_pkg::IDX_PG_MISC, 8'h3c);
        wr(pme_pkg::IDX_PG_MISC, 8'h1c);
        @(posedge sysClk);
        chk(intrClr, 1'b0);
        @(posedge sysClk);
        lowStage <= 1'b1;
        n = 0;
        while (pgOut !== 1'b1 && n < 300) begin
            @(posedge sysClk);
            n++;
        end
        // fast first stage plus mid second stage, plus pin filter latency
        chk(n >= T1 + T2 && n <= T1 + T2 + 6, 1'b1);
        chk(pgMid, 1'b1);
        wr(pme_pkg::IDX_PG_MISC, 8'h1d);
        @(posedge sysClk);
        chk(pgOut, 1'b0);
        rd(pme_pkg::IDX_PG_MISC, 8'h1c);
    endtask
    // on-recovery power switch pulse width
    task automatic on_pulse();
        wr(pme_pkg::IDX_WAKE_OPT, 8'h10);
        @(posedge sysClk);
        lossOn <= 1'b1;
        @(posedge sysClk);
        lossOn <= 1'b0;
        n = 0;
        while (pswN !== 1'b0 && n < 10) begin
            @(posedge sysClk);
            n++;
        end
        n = 0;
        while (pswN === 1'b0 && n < 100) begin
            @(posedge sysClk);
            n++;
        end
        // low for exactly the programmed count of cycles
        chk(n, ON);
    endtask
    // key-set gating, os key pulse, reset sources, mouse selector bit
    task automatic wake_resets();
        @(posedge sysClk);
        keyMatch <= 3'h6;
        @(posedge sysClk);
        keyMatch <= 3'h0;
        @(posedge sysClk);
        chk(kbWake, 1'b0);
        wr(pme_pkg::IDX_WAKE_OPT, 8'he9);
        keyMatch <= 3'h4;
        kbEn <= 1'b1;
        osKey <= 1'b1;
        lowStage <= 1'b0;
        @(posedge sysClk);
        keyMatch <= 3'h2;
        osKey <= 1'b0;
        @(posedge sysClk);
        chk(kbWake, 1'b1);
        chk(pswN, 1'b0);
        keyMatch <= 3'h0;
        @(posedge sysClk);
        chk(kbWake, 1'b1);
        repeat (9) @(posedge sysClk);
        chk(pswN, 1'b1);
        chk(wdtRstN, 1'b0);
        chk(hmRstN, 1'b1);
        wr(pme_pkg::IDX_WAKE_OPT, 8'h00);
        repeat (2) @(posedge sysClk);
        chk(wdtRstN, 1'b1);
        chk(hmRstN, 1'b0);
        lpcN <= 1'b0;
        repeat (6) @(posedge sysClk);
        chk(wdtRstN, 1'b0);
        chk(rstOutN, 5'h00);
        lpcN <= 1'b1;
        wr(pme_pkg::IDX_PG_MISC, 8'h9c);
        @(posedge sysClk);
        chk(mouseHi, 1'b1);
    endtask
    initial begin
        repeat (20) @(posedge sysClk);
        rstN <= 1'b1;
        reset_map();
        events();
        power_good();
        on_pulse();
        wake_resets();
        results();
    end
endmodule
